// File: hdl/tlk_lockdown.sv
// Module: lockdown entry access, translation lookup and address-space invalidation
`timescale 1ns/10ps
module tlk_lockdown
	import tlk_pkg::*;
#(
	parameter int ENTRIES = 32,
	parameter int IDX_W   = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Entry select for reads and writes
	input  wire logic             sel_rd_wr,
	input  wire logic             sel_wr_wr,
	input  wire logic [IDX_W-1:0] sel_idx,
	// Coprocessor word access
	input  wire logic             cp_wr,
	input  wire logic             cp_rd,
	input  wire logic [1:0]       cp_sel,
	input  wire logic [31:0]      cp_wdata,
	output logic      [31:0]      cp_rdata,
	output logic                  cp_rvalid,
	// Address-space invalidation
	input  wire logic             inv_start,
	input  wire logic [9:0]       inv_asid,
	input  wire logic [31:0]      inv_pc,
	input  wire logic             irq_take,
	output logic                  inv_busy,
	output logic                  inv_done,
	output logic                  ret_valid,
	output logic      [31:0]      return_address_register,
	// Translation lookup
	input  wire logic             lk_req,
	input  wire logic [19:0]      lk_vpage,
	input  wire logic [9:0]       lk_asid,
	output logic                  lk_hit,
	output logic      [19:0]      lk_phys_page_number,
	output logic      [2:0]       lk_access_permission,
	output logic      [1:0]       lk_region_size,
	output logic      [TLK_ATTR_W-1:0] lk_attr
);
	// ---------------------------------------------------------------
	// Entry storage
	// ---------------------------------------------------------------
	logic [19:0]           virt_page_number_q [ENTRIES];
	logic                  vnonsecure_q       [ENTRIES];
	logic [9:0]            asid_q             [ENTRIES];
	logic [19:0]           phys_page_number_q [ENTRIES];
	logic [1:0]            region_size_q      [ENTRIES];
	logic [2:0]            access_permission_q[ENTRIES];
	logic                  valid_q            [ENTRIES];
	logic [TLK_ATTR_W-1:0] attr_q             [ENTRIES];
	logic [ENTRIES-1:0]    global_q;
	logic [IDX_W-1:0]      rd_idx_q;
	logic [IDX_W-1:0]      wr_idx_q;
	// Staged words, committed together by the physical word write
	logic [31:0]           stage_virt_q;
	logic [31:0]           stage_attr_q;
	logic                  stage_glob_q;

	tlk_walk_if #(.IDX_W(IDX_W)) wk ();

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Region size to mask of translated page bits; low page bits outside the mask pass through
	function automatic logic [19:0] page_mask(input logic [1:0] sz);
		case (tlk_size_e'(sz))
			TLK_SZ_SUPER: page_mask = 20'hFF000;
			TLK_SZ_4K:    page_mask = 20'hFFFFF;
			TLK_SZ_64K:   page_mask = 20'hFFFF0;
			TLK_SZ_1M:    page_mask = 20'hFFF00;
			default:      page_mask = 20'hFFFFF;
		endcase
	endfunction

	// Reserved permission code 4 is folded to no access
	function automatic logic [2:0] perm_fix(input logic [2:0] ap);
		perm_fix = (ap == 3'h4) ? 3'h0 : ap;
	endfunction

	// ---------------------------------------------------------------
	// Entry selects
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_idx_q <= '0;
			wr_idx_q <= '0;
		end else begin
			if (sel_rd_wr) rd_idx_q <= sel_idx;
			if (sel_wr_wr) wr_idx_q <= sel_idx;
		end
	end

	// Staging of virtual and attribute words; bit 11 of the virtual word is taken as global
	always_ff @(posedge clk) begin
		if (rst) begin
			stage_virt_q <= TLK_RESET_WORD;
			stage_attr_q <= TLK_RESET_WORD;
			stage_glob_q <= 1'b0;
		end else if (cp_wr) begin
			if (cp_sel == TLK_SEL_VIRT) begin
				stage_virt_q <= cp_wdata;
				stage_glob_q <= cp_wdata[11];
			end
			if (cp_sel == TLK_SEL_ATTR) stage_attr_q <= cp_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Entry write and invalidation
	// ---------------------------------------------------------------
	// Software commit and walk kill hit separate entries or the commit wins
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < ENTRIES; i++) begin
				valid_q[i] <= 1'b0;
			end
		end else begin
			if (wk.kill) valid_q[wk.idx] <= 1'b0;
			if (cp_wr && cp_sel == TLK_SEL_PHYS) begin
				valid_q[wr_idx_q] <= cp_wdata[TLK_VALID_BIT];
			end
		end
	end

	// Entry payload, one permission and attribute set per region
	always_ff @(posedge clk) begin
		if (cp_wr && cp_sel == TLK_SEL_PHYS) begin
			phys_page_number_q[wr_idx_q]  <= cp_wdata[31:TLK_PAGE_LSB];
			region_size_q[wr_idx_q]       <= cp_wdata[TLK_SIZE_LSB+:2];
			access_permission_q[wr_idx_q] <= cp_wdata[TLK_PERM_LSB+:3];
			virt_page_number_q[wr_idx_q]  <= stage_virt_q[31:TLK_PAGE_LSB];
			vnonsecure_q[wr_idx_q]        <= stage_virt_q[TLK_VNS_BIT];
			asid_q[wr_idx_q]              <= stage_virt_q[TLK_ASID_W-1:0];
			attr_q[wr_idx_q]              <= stage_attr_q[TLK_ATTR_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) global_q <= '0;
		else if (cp_wr && cp_sel == TLK_SEL_PHYS) global_q[wr_idx_q] <= stage_glob_q;
	end

	// ---------------------------------------------------------------
	// Invalidation walk control
	// ---------------------------------------------------------------
	logic [9:0]  inv_asid_q;
	logic [31:0] inv_pc_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			inv_asid_q <= '0;
			inv_pc_q   <= TLK_RESET_WORD;
		end else if (inv_start && !wk.busy) begin
			inv_asid_q <= inv_asid;
			inv_pc_q   <= inv_pc;
		end
	end

	assign wk.start = inv_start && !wk.busy;
	assign wk.abort = irq_take && wk.busy;
	assign wk.asid  = inv_asid_q;
	// Entries loaded during an interrupt are caught because restart walks all again
	assign wk.hit   = valid_q[wk.idx] && !global_q[wk.idx] && (asid_q[wk.idx] == inv_asid_q);

	tlk_walker #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_walker (
		.clk (clk),
		.rst (rst),
		.w   (wk)
	);

	// Status and return address; the handler returns to the invalidating instruction
	always_ff @(posedge clk) begin
		if (rst) begin
			inv_busy                <= 1'b0;
			inv_done                <= 1'b0;
			ret_valid               <= 1'b0;
			return_address_register <= TLK_RESET_WORD;
		end else begin
			inv_busy  <= wk.busy && !wk.abort;
			inv_done  <= wk.done;
			ret_valid <= wk.abort;
			if (wk.abort) return_address_register <= inv_pc_q + TLK_RET_OFFSET;
		end
	end

	// ---------------------------------------------------------------
	// Word read-back
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cp_rdata  <= TLK_RESET_WORD;
			cp_rvalid <= 1'b0;
		end else begin
			cp_rvalid <= cp_rd;
			if (cp_rd) begin
				case (cp_sel)
					TLK_SEL_VIRT: cp_rdata <= {virt_page_number_q[rd_idx_q], global_q[rd_idx_q],
						vnonsecure_q[rd_idx_q], asid_q[rd_idx_q]};
					TLK_SEL_PHYS: cp_rdata <= {phys_page_number_q[rd_idx_q], 4'h0, region_size_q[rd_idx_q],
						2'h0, access_permission_q[rd_idx_q], valid_q[rd_idx_q]};
					TLK_SEL_ATTR: cp_rdata <= {20'h00000, attr_q[rd_idx_q]};
					default:      cp_rdata <= TLK_RESET_WORD;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Translation lookup, lowest-numbered hit wins
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			lk_hit               <= 1'b0;
			lk_phys_page_number  <= '0;
			lk_access_permission <= '0;
			lk_region_size       <= '0;
			lk_attr              <= '0;
		end else begin
			lk_hit <= 1'b0;
			if (lk_req) begin
				for (int i = ENTRIES - 1; i >= 0; i--) begin
					if (valid_q[i] && (global_q[i] || asid_q[i] == lk_asid) &&
						((virt_page_number_q[i] ^ lk_vpage) & page_mask(region_size_q[i])) == 20'h00000) begin
						lk_hit               <= 1'b1;
						lk_phys_page_number  <= (phys_page_number_q[i] & page_mask(region_size_q[i])) |
							(lk_vpage & ~page_mask(region_size_q[i]));
						lk_access_permission <= perm_fix(access_permission_q[i]);
						lk_region_size       <= region_size_q[i];
						lk_attr              <= attr_q[i];
					end
				end
			end
		end
	end
endmodule

// File: hdl/tlk_pkg.sv
// Package: constants and types for the TLB lockdown entry access block
//
// Function
// - The physical word holds the physical page number in bits 31 to 12.
// - The two-bit region size encodes supersection, 4KB page, 64KB page and 1MB section as 0 to 3.
// - Permission codes 0 to 3 mean no access, supervisor only, no user writes and full access.
// - Permission code 4 is reserved, 5 is supervisor read-only, 6 and 7 read-only for everyone.
// - Bit 0 of the physical word marks the entry locked and valid, and only such entries translate.
// - The attribute word holds the non-secure flag at bit 11 and the domain in bits 10 to 7.
// - The attribute word holds never-execute at 6, type extension at 5:3, cache bits at 2:1, shareable at 0.
// - Subpage permissions are absent, one permission set covers the whole region.
// - Address-space invalidation removes every matching entry, locked ones included.
// - Address-space invalidation leaves global entries untouched.
// - Address-space invalidation is a multi-cycle operation that can be interrupted.
// - An interrupted invalidation reports the instruction address plus 4 as return address.
// - A restarted invalidation also removes matching entries loaded during the interrupt.
// - The virtual word holds the page number at 31:12, non-secure at 10, the identifier at 9:0.
package tlk_pkg;
	// ---------------------------------------------------------------
	// Word selectors on the coprocessor access port
	// ---------------------------------------------------------------
	localparam logic [1:0] TLK_SEL_VIRT  = 2'h0;
	localparam logic [1:0] TLK_SEL_PHYS  = 2'h1;
	localparam logic [1:0] TLK_SEL_ATTR  = 2'h2;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int TLK_PAGE_LSB    = 12;
	localparam int TLK_SIZE_LSB    = 6;
	localparam int TLK_PERM_LSB    = 1;
	localparam int TLK_VALID_BIT   = 0;
	localparam int TLK_VNS_BIT     = 10;
	localparam int TLK_ASID_W      = 10;
	localparam int TLK_ANS_BIT     = 11;
	localparam int TLK_DOM_LSB     = 7;
	localparam int TLK_ATTR_W      = 12;
	localparam logic [31:0] TLK_RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] TLK_RET_OFFSET = 32'h0000_0004;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TLK_SZ_SUPER = 2'h0,
		TLK_SZ_4K    = 2'h1,
		TLK_SZ_64K   = 2'h2,
		TLK_SZ_1M    = 2'h3
	} tlk_size_e;

	// Invalidation sequencer, Gray order idle -> walk -> done
	typedef enum logic [1:0] {
		TLK_ST_IDLE = 2'h0,
		TLK_ST_WALK = 2'h1,
		TLK_ST_DONE = 2'h3
	} tlk_state_e;
endpackage

// File: hdl/tlk_walk_if.sv
// Interface: invalidation walk request and entry compare signals
`timescale 1ns/10ps
interface tlk_walk_if #(parameter int IDX_W = 5);
	logic             start;
	logic             abort;
	logic [9:0]       asid;
	logic [IDX_W-1:0] idx;
	logic             kill;
	logic             busy;
	logic             done;
	logic             hit;

	modport ctl (output start, output abort, output asid, input idx, input kill, input busy, input done, output hit);
	modport seq (input start, input abort, input asid, output idx, output kill, output busy, output done, input hit);
endinterface

// File: hdl/tlk_walker.sv
// Module: multi-cycle address-space invalidation sequencer
`timescale 1ns/10ps
module tlk_walker
	import tlk_pkg::*;
#(
	parameter int ENTRIES = 32,
	parameter int IDX_W   = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Walk channel
	tlk_walk_if.seq  w
);
	tlk_state_e       state_q;
	logic [IDX_W-1:0] idx_q;

	// One entry per cycle; an abort drops the walk, restart begins at entry zero
	always_ff @(posedge clk) begin
		if (rst || w.abort) begin
			state_q <= TLK_ST_IDLE;
			idx_q   <= '0;
		end else begin
			case (state_q)
				TLK_ST_IDLE: begin
					idx_q <= '0;
					if (w.start) begin
						state_q <= TLK_ST_WALK;
					end
				end
				TLK_ST_WALK: begin
					if (idx_q == IDX_W'(ENTRIES - 1)) begin
						state_q <= TLK_ST_DONE;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				TLK_ST_DONE: state_q <= TLK_ST_IDLE;
				default:     state_q <= TLK_ST_IDLE;
			endcase
		end
	end

	assign w.idx  = idx_q;
	assign w.busy = (state_q == TLK_ST_WALK);
	assign w.done = (state_q == TLK_ST_DONE);
	assign w.kill = (state_q == TLK_ST_WALK) && w.hit;
endmodule

// File: verif/tlk_lockdown_assertions.sv
// Checker: port timing of the lockdown entry block
`timescale 1ns/10ps
module tlk_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register port
	input wire logic       cp_rd,
	input wire logic       cp_rvalid,
	// Invalidation
	input wire logic       inv_start,
	input wire logic       irq_take,
	input wire logic       inv_busy,
	input wire logic       inv_done,
	input wire logic       ret_valid,
	// Lookup
	input wire logic       lk_req,
	input wire logic       lk_hit,
	input wire logic [2:0] lk_access_permission
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	rd_answer_a: assert property (cp_rd |=> cp_rvalid)
		else $error("read gave no answer next cycle");
	rd_cause_a: assert property (cp_rvalid |-> $past(cp_rd))
		else $error("read answer without a read");
	walk_starts_a: assert property (inv_start && !inv_busy |-> ##[1:2] inv_busy)
		else $error("walk did not start");
	abort_ret_a: assert property (irq_take && inv_busy |=> ret_valid && !inv_done)
		else $error("abort gave no return pulse");
	done_end_a: assert property (inv_done |=> !inv_done && !inv_busy)
		else $error("done pulse too long or walk still busy");
	done_cause_a: assert property (inv_done |-> $past(inv_busy) || $past(inv_busy, 2))
		else $error("done without a walk");
	hit_cause_a: assert property (lk_hit |-> $past(lk_req))
		else $error("hit without a lookup");
	perm_fold_a: assert property (lk_hit |-> lk_access_permission != 3'h4)
		else $error("reserved permission code reported");
	rst_quiet_a: assert property ($fell(rst) |-> !cp_rvalid && !inv_busy && !inv_done && !lk_hit && !ret_valid)
		else $error("outputs not quiet after reset");
	// Main scenarios reached
	cover property (cp_rvalid);
	cover property (inv_done);
	cover property (ret_valid);
	cover property (lk_hit);
endmodule
bind tlk_lockdown tlk_chk u_chk (.clk(clk), .rst(rst), .cp_rd(cp_rd), .cp_rvalid(cp_rvalid),
	.inv_start(inv_start), .irq_take(irq_take), .inv_busy(inv_busy), .inv_done(inv_done),
	.ret_valid(ret_valid), .lk_req(lk_req), .lk_hit(lk_hit), .lk_access_permission(lk_access_permission));

// File: verif/test_tlb_lockdown_entry_access.sv
// Testbench: self-checking run of the lockdown entry block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_tlb_lockdown_entry_access
	import tlk_pkg::*;
;
	logic        clk, rst, sel_rd_wr, sel_wr_wr, cp_wr, cp_rd, inv_start, irq_take, lk_req;
	logic        cp_rvalid, inv_busy, inv_done, ret_valid, lk_hit;
	logic [4:0]  sel_idx;
	logic [1:0]  cp_sel, lk_region_size, got_sz;
	logic [31:0] cp_wdata, inv_pc, cp_rdata, return_address_register;
	logic [9:0]  inv_asid, lk_asid;
	logic [19:0] lk_vpage, lk_phys_page_number, got_ppn;
	logic [2:0]  lk_access_permission, got_perm;
	logic [11:0] lk_attr, got_attr;
	int          err_count = 0;
	int          total_checks = 0;
	// Design under test
	tlk_lockdown dut (.clk(clk), .rst(rst), .sel_rd_wr(sel_rd_wr), .sel_wr_wr(sel_wr_wr), .sel_idx(sel_idx),
		.cp_wr(cp_wr), .cp_rd(cp_rd), .cp_sel(cp_sel), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
		.cp_rvalid(cp_rvalid), .inv_start(inv_start), .inv_asid(inv_asid), .inv_pc(inv_pc),
		.irq_take(irq_take), .inv_busy(inv_busy), .inv_done(inv_done), .ret_valid(ret_valid),
		.return_address_register(return_address_register), .lk_req(lk_req), .lk_vpage(lk_vpage),
		.lk_asid(lk_asid), .lk_hit(lk_hit), .lk_phys_page_number(lk_phys_page_number),
		.lk_access_permission(lk_access_permission), .lk_region_size(lk_region_size), .lk_attr(lk_attr));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Bounded wait for a one-cycle output; looks before the first edge since it may already stand
	task automatic await(ref logic s, input int lim, output bit got);
		got = 0;
		for (int i = 0; i < lim && !got; i++) begin
			got = (s === 1'b1);
			if (!got) cyc();
		end
	endtask
	// Select, then virtual, attribute and physical last so the commit sees staged words
	task automatic put(input logic [4:0] idx, input logic [31:0] va, input logic [31:0] at, input logic [31:0] pa);
		sel_idx = idx;
		sel_wr_wr = 1;
		cyc();
		sel_wr_wr = 0;
		cp_wr = 1;
		cp_sel = TLK_SEL_VIRT;
		cp_wdata = va;
		cyc();
		cp_sel = TLK_SEL_ATTR;
		cp_wdata = at;
		cyc();
		cp_sel = TLK_SEL_PHYS;
		cp_wdata = pa;
		cyc();
		cp_wr = 0;
		cyc();
	endtask
	task automatic rd(input logic [4:0] idx, input logic [1:0] sel, input logic [31:0] exp);
		bit got;
		sel_idx = idx;
		sel_rd_wr = 1;
		cyc();
		sel_rd_wr = 0;
		cp_sel = sel;
		cp_rd = 1;
		cyc();
		cp_rd = 0;
		await(cp_rvalid, 3, got);
		`CHK("cp_rvalid", 1'b1, got)
		`CHK("cp_rdata", exp, cp_rdata)
		cyc();
	endtask
	// Lookup; results are captured in the cycle the hit stands
	task automatic look(input logic [19:0] vp, input logic [9:0] as, input bit exp);
		bit got;
		lk_vpage = vp;
		lk_asid = as;
		lk_req = 1;
		cyc();
		lk_req = 0;
		await(lk_hit, 3, got);
		{got_ppn, got_perm, got_sz, got_attr} = {lk_phys_page_number, lk_access_permission, lk_region_size, lk_attr};
		`CHK("lk_hit", exp, got)
		cyc();
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic sc_regs();
		put(5'h03, 32'hABCD_E555, 32'h0000_0ABC, 32'h1234_50CB);
		rd(5'h03, TLK_SEL_VIRT, 32'hABCD_E555);
		rd(5'h03, TLK_SEL_ATTR, 32'h0000_0ABC);
		rd(5'h03, TLK_SEL_PHYS, 32'h1234_50CB);
		rd(5'h03, 2'h3, 32'h0000_0000);
		look(20'hABCDE, 10'h155, 1'b1);
		`CHK("lk_attr", 12'hABC, got_attr)
		`CHK("lk_ppn", 20'h123DE, got_ppn)
		look(20'hABCFF, 10'h155, 1'b1);
		look(20'hABCDE, 10'h154, 1'b0);
	endtask
	task automatic sc_codes();
		for (int i = 0; i < 8; i++) begin
			put(5'h08 + i[4:0], {i[3:0], 28'h000_0020}, 32'h0, {i[7:0], 12'h000, 4'h0, i[1:0], 2'h0, i[2:0], 1'b1});
			look({i[3:0], 16'h0000}, 10'h020, 1'b1);
			`CHK("lk_region_size", i[1:0], got_sz)
			`CHK("lk_perm", (i == 4) ? 3'h0 : i[2:0], got_perm)
			`CHK("lk_ppn", {i[7:0], 12'h000}, got_ppn)
		end
		// Page chosen apart from the 1MB entry at 0x70000 loaded above
		put(5'h14, 32'h7800_0020, 32'h0, 32'h0000_1046);
		look(20'h78000, 10'h020, 1'b0);
	endtask
	task automatic sc_inv();
		bit got;
		put(5'h15, 32'h5000_0005, 32'h0, 32'h0000_1047);
		put(5'h16, 32'h5100_0805, 32'h0, 32'h0000_2047);
		put(5'h17, 32'h5200_0006, 32'h0, 32'h0000_3047);
		inv_asid = 10'h005;
		inv_start = 1;
		cyc();
		inv_start = 0;
		await(inv_done, 60, got);
		`CHK("inv_done", 1'b1, got)
		look(20'h50000, 10'h005, 1'b0);
		look(20'h51000, 10'h005, 1'b1);
		look(20'h52000, 10'h006, 1'b1);
	endtask
	task automatic sc_abort();
		bit got;
		put(5'h18, 32'h6000_0007, 32'h0, 32'h0000_4047);
		inv_asid = 10'h007;
		inv_pc = 32'h0000_2000;
		inv_start = 1;
		cyc();
		inv_start = 0;
		cyc(10);
		irq_take = 1;
		cyc();
		irq_take = 0;
		await(ret_valid, 3, got);
		`CHK("ret_valid", 1'b1, got)
		`CHK("return_address", 32'h0000_2004, return_address_register)
		put(5'h19, 32'h6100_0007, 32'h0, 32'h0000_5047);
		inv_start = 1;
		cyc();
		inv_start = 0;
		await(inv_done, 60, got);
		`CHK("inv_done", 1'b1, got)
		look(20'h60000, 10'h007, 1'b0);
		look(20'h61000, 10'h007, 1'b0);
	endtask
	// ---------------------------------------------------------------
	// Clock, sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst, sel_rd_wr, sel_wr_wr, cp_wr, cp_rd, inv_start, irq_take, lk_req} = 8'h80;
		{sel_idx, cp_sel, cp_wdata, inv_pc, inv_asid, lk_asid, lk_vpage} = '0;
		cyc(12);
		rst = 0;
		sc_regs();
		sc_codes();
		sc_inv();
		sc_abort();
		stop_test();
	end
	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end
endmodule
